//--- temp_comp_params.svh
`ifndef TEMP_COMP_PARAMS_SVH
`define TEMP_COMP_PARAMS_SVH

// ****************************************
// Register offsets are word indices; the byte address is four times the index
// ****************************************
`define REG_TEMPERATURE_PLUS_OFFSET 8'h79
`define REG_PROXIMITY_VALUE_LOW 8'h7a
`define REG_PROXIMITY_VALUE_HIGH 8'h7b
`define REG_COMP_VALUE_LOW 8'h7c
`define REG_COMP_VALUE_HIGH 8'h7d
`define REG_LUT_BASE 8'h80
`define LUT_ENTRIES 47
`define TEMP_OFFSET_C 64
`define LUT_MIN_TEMP_C (-48)
`define LUT_STEP_C 4
`define LUT_MIN_CODE 8'h10
`define GAIN_FRAC_BITS 14
`define GAIN_UNITY 16'h4000
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

//--- temp_comp_pkg.sv
package temp_comp_pkg;
    typedef logic [15:0] gain_code_t;
    typedef enum logic [1:0] {wr_idle, wr_resp} wr_state_t;
endpackage

//--- gain_multiplier.sv
`timescale 1ns/1ps
`default_nettype none
module gain_multiplier #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] raw_value,
    input wire temp_comp_pkg::gain_code_t gain_code,
    output logic [WIDTH-1:0] comp_value
);
    import temp_comp_pkg::*;
    `include "temp_comp_params.svh"
    logic [WIDTH+15:0] product;
    logic [WIDTH+15:0] scaled;
    // Gain code has 14 fraction bits; saturate rather than wrap above full scale
    always_comb begin
        product = raw_value * gain_code;
        scaled = product >> `GAIN_FRAC_BITS;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_value <= '0;
        end else if (|scaled[WIDTH+15:WIDTH]) begin
            comp_value <= '1;
        end else begin
            comp_value <= scaled[WIDTH-1:0];
        end
    end
endmodule
`default_nettype wire

//--- temp_gain_compensation_lut.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module temp_gain_compensation_lut #(
    parameter int PROX_WIDTH = 16,
    parameter int ENTRIES = 47
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] temperature_plus_offset_in,
    input wire logic [15:0] tank_loss_resistance,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] compensated_value
);
    import temp_comp_pkg::*;
    `include "temp_comp_params.svh"

    // ****************************************
    // Operating notes
    // ****************************************
    // Register map, in word indices; byte address is four times the index:
    //   0x79       temperature code, degrees plus 64, read only
    //   0x7a/0x7b  raw proximity, low then high byte, read only
    //   0x7c/0x7d  compensated proximity, low then high byte, read only
    //   0x80..0xdd gain table, entry n high byte at 0x80+2n, low at 0x81+2n
    // Entry n belongs to the temperature -48 + 4n degrees, 47 entries in all.
    // Temperature code 0x10 is -48 degrees, so entry n starts at code 0x10 + 4n.
    // Codes between two points use the lower point; no interpolation is done,
    // which keeps the select path to two compares, a subtract and one shift.
    // Codes below the first point use entry 0 and codes past the last use
    // entry 46, so every code selects a defined gain even before calibration.
    //
    // Gain codes carry 14 fraction bits: 0x4000 is unity, 0xffff just under 4.
    // The product is cut back by 14 bits and saturates at full scale, so a
    // large gain on a large reading gives 0xffff and never wraps to a small one.
    //
    // The table is selected by the reported temperature code, not by any
    // other estimate of ambient, so a calibration made by reading the code
    // back lines up with the entry that the hardware will apply.
    //
    // Bytes of one entry update independently. Between the two byte writes
    // the entry holds a mixed value; software that recalibrates a live sensor
    // should expect a few cycles of a half-updated gain.
    //
    // After reset every entry is unity. No thermistor curve is built in, so
    // the flat preset leaves the reading uncompensated until the table is loaded.
    //
    // Latency: three registers from the input pins to compensated_value.
    //
    // Bus: one write and one read may be under way at a time. Write address
    // and data are taken in either order; the response follows once both are
    // in. Only wstrb[0] and wdata[7:0] matter, as every register is a byte.
    // Writes outside the table answer SLVERR, but those above byte 0x3ff still write the entry that bits [9:2] select; reads of an
    // unmapped index answer SLVERR with zero data.
    // The ready signals are registered, so each costs an idle cycle between
    // transfers; the trade buys short timing paths at this clock rate.

    // ****************************************
    // State
    // ****************************************
    gain_code_t gain_table [ENTRIES];
    logic [7:0] temperature_plus_offset;
    logic [15:0] proximity;
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wr_state_t wr_state;
    logic [5:0] sel_index;
    logic [15:0] comp_raw;
    logic [7:0] windex;
    logic [7:0] rindex;
    logic [31:0] next_rdata;
    logic next_rerr;
    logic wr_fire;

    // ****************************************
    // Data path
    // ****************************************
    // Capture measured inputs each cycle so reads are coherent
    // Both readouts and the multiplier see the same captured sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temperature_plus_offset <= 8'h00;
            proximity <= 16'h0000;
        end else begin
            temperature_plus_offset <= temperature_plus_offset_in;
            proximity <= tank_loss_resistance;
        end
    end

    // Map reported code to a table slot; clamp so out-of-range codes still select
    always_comb begin
        if (temperature_plus_offset < `LUT_MIN_CODE) begin
            sel_index = 6'd0;
        end else if (((temperature_plus_offset - `LUT_MIN_CODE) >> 2) >= 8'(ENTRIES)) begin
            sel_index = 6'(ENTRIES - 1);
        end else begin
            sel_index = 6'((temperature_plus_offset - `LUT_MIN_CODE) >> 2);
        end
    end

    // Scale the captured reading by the selected entry
    // The table read is combinational; the multiplier registers its result,
    // so a table write shows on the output two edges later
    gain_multiplier #(.WIDTH(16)) u_mult (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw_value(proximity),
        .gain_code(gain_table[sel_index]),
        .comp_value(comp_raw)
    );

    // Output register, so the port comes straight from a flip-flop
    // Costs one cycle of latency but isolates the multiplier from the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compensated_value <= 16'h0000;
        end else begin
            compensated_value <= comp_raw;
        end
    end

    // ****************************************
    // AXI write path
    // ****************************************
    assign windex = aw_addr[9:2];
    assign wr_fire = aw_held && w_held && wr_state == wr_idle;

    // Address and data may arrive in either order; hold each until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && wr_state == wr_idle;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && wr_state == wr_idle;
        end
    end

    // Table: preset default, byte-wise writes; indices 0x80+2n high, 0x81+2n low
    // Writes with wstrb[0] low are answered but leave the table alone
    // Even index is the high byte, odd index the low byte of one entry
    // Out-of-range codes are clamped by the select logic to entry 0 or entry 46
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < ENTRIES; i++) begin
                gain_table[i] <= `GAIN_UNITY;
            end
        end else if (wr_fire && w_strb[0] && windex >= `REG_LUT_BASE
                     && windex < 8'(`REG_LUT_BASE + 2 * ENTRIES)) begin
            if (!windex[0]) begin
                gain_table[6'((windex - `REG_LUT_BASE) >> 1)][15:8] <= w_data[7:0];
            end else begin
                gain_table[6'((windex - `REG_LUT_BASE) >> 1)][7:0] <= w_data[7:0];
            end
        end
    end

    // Write response: raised the edge after both halves are held,
    // held until bready; new writes are refused until it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= wr_idle;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else begin
            unique case (wr_state)
                wr_idle: begin
                    if (wr_fire) begin
                        wr_state <= wr_resp;
                        s_axi_bvalid <= 1'b1;
                        // Only table bytes are writable; everything else errors
                        s_axi_bresp <= (windex >= `REG_LUT_BASE
                                        && windex < 8'(`REG_LUT_BASE + 2 * ENTRIES)
                                        && aw_addr[31:10] == 22'h0)
                                       ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                    end
                end
                wr_resp: begin
                    if (s_axi_bready) begin
                        wr_state <= wr_idle;
                        s_axi_bvalid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // AXI read path
    // ****************************************
    // Read data is decoded from the live address and stored at the handshake
    assign rindex = s_axi_araddr[9:2];

    always_comb begin
        next_rdata = 32'h0;
        next_rerr = 1'b0;
        if (s_axi_araddr[31:10] != 22'h0) begin
            next_rerr = 1'b1;
        end else if (rindex == `REG_TEMPERATURE_PLUS_OFFSET) begin
            next_rdata = {24'h0, temperature_plus_offset};
        end else if (rindex == `REG_PROXIMITY_VALUE_LOW) begin
            next_rdata = {24'h0, proximity[7:0]};
        end else if (rindex == `REG_PROXIMITY_VALUE_HIGH) begin
            next_rdata = {24'h0, proximity[15:8]};
        end else if (rindex == `REG_COMP_VALUE_LOW) begin
            next_rdata = {24'h0, compensated_value[7:0]};
        end else if (rindex == `REG_COMP_VALUE_HIGH) begin
            next_rdata = {24'h0, compensated_value[15:8]};
        end else if (rindex >= `REG_LUT_BASE && rindex < 8'(`REG_LUT_BASE + 2 * ENTRIES)) begin
            next_rdata = rindex[0]
                ? {24'h0, gain_table[6'((rindex - `REG_LUT_BASE) >> 1)][7:0]}
                : {24'h0, gain_table[6'((rindex - `REG_LUT_BASE) >> 1)][15:8]};
        end else begin
            next_rerr = 1'b1;
        end
    end

    // One read at a time; arready only while no answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rerr ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- temp_comp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module temp_comp_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] temperature_plus_offset_in,
    input wire logic [15:0] tank_loss_resistance,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] compensated_value
);
    logic ar_ok;
    logic [7:0] prox_lo;
    // Read handshake and low proximity byte
    assign ar_ok = s_axi_arvalid && s_axi_arready;
    assign prox_lo = tank_loss_resistance[7:0];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_temp_readout: assert property (ar_ok && s_axi_araddr == 32'h1e4
        && $stable(temperature_plus_offset_in)
        |=> s_axi_rdata == {24'h0, $past(temperature_plus_offset_in)}) else $error("temp read");
    a_prox_readout: assert property (ar_ok && s_axi_araddr == 32'h1e8
        && $stable(prox_lo) |=> s_axi_rdata == {24'h0, $past(prox_lo)}) else $error("prox read");
    a_read_answer: assert property (ar_ok |=> s_axi_rvalid) else $error("no read answer");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
    a_zero_product: assert property ((tank_loss_resistance == 16'h0)[*4]
        |-> compensated_value == 16'h0) else $error("zero product");
    a_unmapped_read: assert property (ar_ok && s_axi_araddr[31:10] != 22'h0
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule
bind temp_gain_compensation_lut temp_comp_monitor u_temp_comp_monitor (.*);
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic [7:0] temperature_plus_offset_in;
    logic [15:0] tank_loss_resistance, compensated_value;
    int fail_count = 0;
    int cmp_count = 0;
    temp_gain_compensation_lut u_temp_gain_compensation_lut (.*);
    // ****
    // Bus tasks
    // ****
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // Response ready is raised with the request and held until the answer is seen
    task automatic wchk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    // Data path is three edges deep; five edges leave margin after the drive edge
    task automatic pchk(input logic [7:0] t, input logic [15:0] p, input logic [15:0] e);
        temperature_plus_offset_in <= t;
        tank_loss_resistance <= p;
        repeat (5) @(posedge aclk);
        chk("compensated", {16'h0, e}, {16'h0, compensated_value});
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Clock and watchdog
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        repeat (3000) @(posedge aclk);
        fail_count++;
        give_verdict;
    end
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hf;
        temperature_plus_offset_in = 8'h10;
        tank_loss_resistance = 16'h1234;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk(32'h1e4, 32'h10, 2'b00);
        rchk(32'h1e8, 32'h34, 2'b00);
        rchk(32'h1ec, 32'h12, 2'b00);
        rchk(32'h370, 32'h40, 2'b00);
        rchk(32'h374, 32'h00, 2'b00);
        pchk(8'h10, 16'h1234, 16'h1234);
        wchk(32'h200, 32'h80, 2'b00);
        wchk(32'h370, 32'h20, 2'b00);
        rchk(32'h200, 32'h80, 2'b00);
        rchk(32'h204, 32'h00, 2'b00);
        pchk(8'h10, 16'h1234, 16'h2468);
        pchk(8'h14, 16'h1234, 16'h1234);
        pchk(8'h05, 16'h1234, 16'h2468);
        pchk(8'hc7, 16'h1234, 16'h1234);
        pchk(8'hc8, 16'h1234, 16'h091a);
        pchk(8'hff, 16'h1234, 16'h091a);
        pchk(8'h10, 16'hffff, 16'hffff);
        wchk(32'h204, 32'h01, 2'b00);
        pchk(8'h10, 16'h4000, 16'h8001);
        rchk(32'h1f0, 32'h01, 2'b00);
        rchk(32'h1f4, 32'h80, 2'b00);
        wchk(32'h208, 32'h80, 2'b00);
        wchk(32'h20c, 32'h01, 2'b00);
        pchk(8'h14, 16'h4000, 16'h8001);
        pchk(8'h10, 16'h0000, 16'h0000);
        wchk(32'h1e4, 32'h55, 2'b10);
        rchk(32'h1e4, 32'h10, 2'b00);
        rchk(32'h400, 32'h0, 2'b10);
        give_verdict;
    end
endmodule
`default_nettype wire
